// ---- verilog/bsc_pkg.sv ----
// Shared constants, types and helpers for the branch, skip and call unit.
// Assumes an upstream decoder that classifies each instruction.
package bsc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PC_W = 22; // Program counter width.

    // ------------------------------------------------------------------
    // Operation codes and sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE                    = 5'b00000,
        OP_EXTENDED_INDIRECT_CALL  = 5'b00001,
        OP_COMPARE_SKIP_EQUAL      = 5'b00010,
        OP_SKIP_REG_BIT_CLEAR      = 5'b00011,
        OP_SKIP_REG_BIT_SET        = 5'b00100,
        OP_SKIP_IO_BIT_CLEAR       = 5'b00101,
        OP_SKIP_IO_BIT_SET         = 5'b00110,
        OP_BRANCH_STATUS_BIT_SET   = 5'b00111,
        OP_BRANCH_STATUS_BIT_CLEAR = 5'b01000,
        OP_BRANCH_SIGNED_GE        = 5'b01001,
        OP_BRANCH_SIGNED_LT        = 5'b01010,
        OP_BRANCH_HALF_CARRY_SET   = 5'b01011,
        OP_BRANCH_HALF_CARRY_CLEAR = 5'b01100,
        OP_BRANCH_OVERFLOW_SET     = 5'b01101,
        OP_BRANCH_OVERFLOW_CLEAR   = 5'b01110,
        OP_BRANCH_CARRY_CLEAR      = 5'b01111,
        OP_BRANCH_CARRY_SET        = 5'b10000,
        OP_BRANCH_UNSIGNED_GE      = 5'b10001,
        OP_BRANCH_UNSIGNED_LT      = 5'b10010,
        OP_BRANCH_TRANSFER_FLAG_SET   = 5'b10011,
        OP_BRANCH_TRANSFER_FLAG_CLEAR = 5'b10100,
        OP_LOAD_DIRECT             = 5'b10101
    } bsc_op_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_IO_WAIT = 2'b01,
        ST_EXEC    = 2'b10
    } bsc_state_t;

    // ------------------------------------------------------------------
    // Status flag positions in the status_flags_register
    // ------------------------------------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0; // Carry.
    localparam logic [2:0] FLAG_N = 3'h2; // Negative.
    localparam logic [2:0] FLAG_V = 3'h3; // Overflow.
    localparam logic [2:0] FLAG_H = 3'h5; // Half carry.
    localparam logic [2:0] FLAG_T = 3'h6; // Bit transfer.

    // ------------------------------------------------------------------
    // Cycle counts, program counter steps and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] CYC_ZERO  = 3'h0;
    localparam logic [2:0] CYC_ONE   = 3'h1;
    localparam logic [2:0] CYC_TWO   = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [PC_W-1:0] PC_ZERO     = 22'h0;
    localparam logic [PC_W-1:0] PC_STEP     = 22'h1;
    localparam logic [PC_W-1:0] PC_STEP_TWO = 22'h2;

    // Adds two program counter values, wrapping at the counter width.
    function automatic logic [PC_W-1:0] bsc_pc_add(
        input logic [PC_W-1:0] a,
        input logic [PC_W-1:0] b);
        return a + b;
    endfunction

    // Sign-extends a 7-bit relative branch offset to counter width.
    function automatic logic [PC_W-1:0] bsc_sext_k(input logic [6:0] k);
        return {{15{k[6]}}, k};
    endfunction

endpackage

// ---- verilog/bsc_cond_if.sv ----
// Interface between the sequencer and the condition evaluator.
// Assumes both ends run on the same clock and share the package.
`timescale 1ns/10ps
interface bsc_cond_if;
    import bsc_pkg::*;
    bsc_op_t    op;      // Operation under test.
    logic [7:0] flags;   // Current status flags.
    logic [7:0] rd_val;  // First register operand.
    logic [7:0] rr_val;  // Second register operand.
    logic [2:0] bit_sel; // Bit or flag selector.
    logic [7:0] io_val;  // Byte read from the I/O location.
    logic       take;    // Branch or skip condition holds.

    modport core (output op, flags, rd_val, rr_val, bit_sel, io_val,
                  input take);
    modport eval (input op, flags, rd_val, rr_val, bit_sel, io_val,
                  output take);
endinterface

// ---- verilog/bsc_cond_eval.sv ----
// Condition evaluator: decides whether a branch or skip is taken.
// Assumes purely combinational use inside the sequencer's cycle.
`timescale 1ns/10ps
module bsc_cond_eval (
    // Operands in, decision out.
    bsc_cond_if.eval cif
);
    import bsc_pkg::*;

    // ------------------------------------------------------------------
    // Selected bits
    // ------------------------------------------------------------------
    logic reg_bit_w;  // Chosen bit of the register operand.
    logic io_bit_w;   // Chosen bit of the I/O byte.
    logic flag_bit_w; // Chosen status flag.
    logic n_x_v_w;    // Signed less-than indicator.

    assign reg_bit_w  = cif.rr_val[cif.bit_sel];
    assign io_bit_w   = cif.io_val[cif.bit_sel];
    assign flag_bit_w = cif.flags[cif.bit_sel];
    assign n_x_v_w    = cif.flags[FLAG_N] ^ cif.flags[FLAG_V];

    // ------------------------------------------------------------------
    // Decision per operation
    // ------------------------------------------------------------------
    // Unknown operations never branch or skip.
    always_comb begin
        cif.take = 1'b0;
        case (cif.op)
            OP_COMPARE_SKIP_EQUAL: begin
                cif.take = (cif.rd_val == cif.rr_val);
            end
            OP_SKIP_REG_BIT_CLEAR:  cif.take = !reg_bit_w;
            OP_SKIP_REG_BIT_SET:    cif.take = reg_bit_w;
            OP_SKIP_IO_BIT_CLEAR:   cif.take = !io_bit_w;
            OP_SKIP_IO_BIT_SET:     cif.take = io_bit_w;
            OP_BRANCH_STATUS_BIT_SET:   cif.take = flag_bit_w;
            OP_BRANCH_STATUS_BIT_CLEAR: cif.take = !flag_bit_w;
            OP_BRANCH_SIGNED_GE:    cif.take = !n_x_v_w;
            OP_BRANCH_SIGNED_LT:    cif.take = n_x_v_w;
            OP_BRANCH_HALF_CARRY_SET:   cif.take = cif.flags[FLAG_H];
            OP_BRANCH_HALF_CARRY_CLEAR: cif.take = !cif.flags[FLAG_H];
            OP_BRANCH_OVERFLOW_SET:   cif.take = cif.flags[FLAG_V];
            OP_BRANCH_OVERFLOW_CLEAR: cif.take = !cif.flags[FLAG_V];
            OP_BRANCH_CARRY_CLEAR:  cif.take = !cif.flags[FLAG_C];
            OP_BRANCH_CARRY_SET:    cif.take = cif.flags[FLAG_C];
            OP_BRANCH_UNSIGNED_GE:  cif.take = !cif.flags[FLAG_C];
            OP_BRANCH_UNSIGNED_LT:  cif.take = cif.flags[FLAG_C];
            OP_BRANCH_TRANSFER_FLAG_SET: begin
                cif.take = cif.flags[FLAG_T];
            end
            OP_BRANCH_TRANSFER_FLAG_CLEAR: begin
                cif.take = !cif.flags[FLAG_T];
            end
            default: cif.take = 1'b0;
        endcase
    end

endmodule

// ---- verilog/bsc_branch_skip_call_unit.sv ----
// Sequencer for calls, skips, branches and the direct load.
// Assumes a decoder that presents one operation with its operands.
//
// Contract
// - Extended call jumps to high bits and Z.
// - Equal registers skip next instruction, no flags.
// - Register bit skip on clear or set.
// - I/O bit skip takes two to four cycles.
// - Branch when chosen status flag is one.
// - Branch when chosen status flag is zero.
// - Signed branches use negative XOR overflow.
// - Half carry branches on set or clear.
// - Overflow branches on set or clear.
// - Carry branches on clear or set.
// - Unsigned branches alias the carry branches.
// - Transfer flag branches on set or clear.
// - Direct load copies data byte in two cycles.
`timescale 1ns/10ps
module bsc_branch_skip_call_unit (
    // Clock, reset and enable.
    input  logic                       clk_sys_i,
    input  logic                       arst_n_i,
    input  logic                       ce_i,
    // Decoded operation.
    input  logic                       issue_i,
    input  bsc_pkg::bsc_op_t           op_i,
    input  logic [bsc_pkg::PC_W-1:0]   pc_i,
    input  logic [7:0]                 rd_val_i,
    input  logic [7:0]                 rr_val_i,
    input  logic [4:0]                 dest_i,
    input  logic [2:0]                 bit_sel_i,
    input  logic [6:0]                 k_off_i,
    input  logic                       two_word_next_i,
    input  logic [15:0]                z_ptr_i,
    input  logic [5:0]                 ext_high_i,
    input  logic [7:0]                 flags_i,
    input  logic [15:0]                load_addr_i,
    input  logic [4:0]                 io_addr_i,
    // I/O space read.
    output logic                       io_rd_o,
    output logic [4:0]                 io_addr_o,
    input  logic [7:0]                 io_rdata_i,
    // Data space read.
    output logic                       data_rd_o,
    output logic [15:0]                data_addr_o,
    input  logic [7:0]                 data_rdata_i,
    // Results.
    output logic                       busy_o,
    output logic                       done_o,
    output logic [bsc_pkg::PC_W-1:0]   pc_next_o,
    output logic                       push_o,
    output logic [bsc_pkg::PC_W-1:0]   ret_addr_o,
    output logic                       reg_we_o,
    output logic [4:0]                 reg_waddr_o,
    output logic [7:0]                 reg_wdata_o
);
    import bsc_pkg::*;

    // ------------------------------------------------------------------
    // State and held operands
    // ------------------------------------------------------------------
    bsc_state_t      state_q;   // Sequencer state.
    logic [2:0]      cnt_q;     // Cycles left in execution.
    bsc_op_t         op_q;      // Operation in flight.
    logic [PC_W-1:0] pc_q;      // Counter of the operation in flight.
    logic [2:0]      bit_q;     // Held bit selector for the I/O test.
    logic            two_q;     // Held length of the next instruction.
    logic [PC_W-1:0] pcn_q;     // New program counter.
    logic [PC_W-1:0] ret_q;     // Return address for the call.
    logic            busy_q;    // Operation in flight.
    logic            done_q;    // Completion pulse.
    logic            push_q;    // Return address push pulse.
    logic            io_rd_q;   // I/O read strobe.
    logic [4:0]      io_addr_q; // I/O read address.
    logic            data_rd_q; // Data read strobe.
    logic [15:0]     data_addr_q; // Data read address.
    logic            we_q;      // Register write pulse.
    logic [4:0]      waddr_q;   // Register write index.
    logic [7:0]      wdata_q;   // Register write byte.

    bsc_cond_if cif ();

    // Condition evaluator shared by issue and the I/O wait.
    bsc_cond_eval u_cond (
        .cif (cif)
    );

    // ------------------------------------------------------------------
    // Decode and next values
    // ------------------------------------------------------------------
    logic            go_w;       // Operation accepted this cycle.
    logic            wait_w;     // Waiting for the I/O byte.
    logic            fin_w;      // Last execution cycle.
    logic            is_io_w;    // I/O bit skip.
    logic            is_call_w;  // Extended indirect call.
    logic            is_load_w;  // Direct load.
    logic            is_skip_w;  // Register compare or bit skip.
    logic            two_b_w;    // Length of the instruction to skip.
    logic [PC_W-1:0] pc_b_w;     // Base counter for skips.
    logic [PC_W-1:0] skip_w;     // Words skipped.
    logic [PC_W-1:0] pc_skip_w;  // Counter after a skip test.
    logic [2:0]      cyc_skip_w; // Cycles of a skip test.
    logic [PC_W-1:0] pc_seq_w;   // Next sequential counter.
    logic [PC_W-1:0] pc_br_w;    // Counter after a branch test.
    logic [2:0]      cyc_br_w;   // Cycles of a branch test.
    logic [PC_W-1:0] pc_iss_w;   // Counter chosen at issue.
    logic [2:0]      cyc_iss_w;  // Cycles chosen at issue.

    assign go_w   = issue_i && (state_q == ST_IDLE) && (op_i != OP_NONE);
    assign wait_w = (state_q == ST_IO_WAIT);
    assign fin_w  = (state_q == ST_EXEC) && (cnt_q == CYC_ONE);

    assign is_io_w   = (op_i == OP_SKIP_IO_BIT_CLEAR) ||
                       (op_i == OP_SKIP_IO_BIT_SET);
    assign is_call_w = (op_i == OP_EXTENDED_INDIRECT_CALL);
    assign is_load_w = (op_i == OP_LOAD_DIRECT);
    assign is_skip_w = (op_i == OP_COMPARE_SKIP_EQUAL) ||
                       (op_i == OP_SKIP_REG_BIT_CLEAR) ||
                       (op_i == OP_SKIP_REG_BIT_SET);

    // The I/O test replays the held operation one cycle later.
    assign cif.op      = wait_w ? op_q : op_i;
    assign cif.flags   = flags_i;
    assign cif.rd_val  = rd_val_i;
    assign cif.rr_val  = rr_val_i;
    assign cif.bit_sel = wait_w ? bit_q : bit_sel_i;
    assign cif.io_val  = io_rdata_i;

    // A taken skip passes over one or two words.
    assign two_b_w    = wait_w ? two_q : two_word_next_i;
    assign pc_b_w     = wait_w ? pc_q : pc_i;
    assign skip_w     = !cif.take ? PC_ZERO :
                        (two_b_w ? PC_STEP_TWO : PC_STEP);
    assign pc_skip_w  = bsc_pc_add(pc_b_w, bsc_pc_add(skip_w, PC_STEP));
    assign cyc_skip_w = !cif.take ? CYC_ONE :
                        (two_b_w ? CYC_THREE : CYC_TWO);

    // Branches add the signed offset to the incremented counter.
    assign pc_seq_w = bsc_pc_add(pc_i, PC_STEP);
    assign pc_br_w  = cif.take ?
                      bsc_pc_add(pc_seq_w, bsc_sext_k(k_off_i)) :
                      pc_seq_w;
    assign cyc_br_w = cif.take ? CYC_TWO : CYC_ONE;

    // Pick the counter and the cycle count by operation class.
    assign pc_iss_w  = is_call_w ? {ext_high_i, z_ptr_i} :
                       is_load_w ? bsc_pc_add(pc_i, PC_STEP_TWO) :
                       is_skip_w ? pc_skip_w : pc_br_w;
    assign cyc_iss_w = is_call_w ? CYC_THREE :
                       is_load_w ? CYC_TWO :
                       is_skip_w ? cyc_skip_w : cyc_br_w;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Counts down the cycles of the operation in flight.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= CYC_ZERO;
        end else if (ce_i) begin
            case (state_q)
                ST_IDLE: if (go_w) begin
                    state_q <= is_io_w ? ST_IO_WAIT : ST_EXEC;
                    cnt_q   <= cyc_iss_w;
                end
                // The I/O byte arrives now; the skip length is known.
                ST_IO_WAIT: begin
                    state_q <= ST_EXEC;
                    cnt_q   <= cyc_skip_w;
                end
                ST_EXEC: if (fin_w) begin
                    state_q <= ST_IDLE;
                end else begin
                    cnt_q <= cnt_q - CYC_ONE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Holds the operands and the new counter of the operation.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_q        <= OP_NONE;
            pc_q        <= PC_ZERO;
            bit_q       <= 3'h0;
            two_q       <= 1'b0;
            pcn_q       <= PC_ZERO;
            ret_q       <= PC_ZERO;
            io_addr_q   <= 5'h0;
            data_addr_q <= 16'h0;
            waddr_q     <= 5'h0;
        end else if (ce_i && go_w) begin
            op_q        <= op_i;
            pc_q        <= pc_i;
            bit_q       <= bit_sel_i;
            two_q       <= two_word_next_i;
            pcn_q       <= pc_iss_w;
            ret_q       <= pc_seq_w;
            io_addr_q   <= io_addr_i;
            data_addr_q <= load_addr_i;
            waddr_q     <= dest_i;
        end else if (ce_i && wait_w) begin
            pcn_q <= pc_skip_w;
        end
    end

    // Strobes, completion and the loaded byte; flags are never written.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            push_q    <= 1'b0;
            io_rd_q   <= 1'b0;
            data_rd_q <= 1'b0;
            we_q      <= 1'b0;
            wdata_q   <= 8'h0;
        end else if (ce_i) begin
            busy_q    <= go_w || (busy_q && !fin_w);
            done_q    <= fin_w;
            push_q    <= fin_w && (op_q == OP_EXTENDED_INDIRECT_CALL);
            io_rd_q   <= go_w && is_io_w;
            data_rd_q <= go_w && is_load_w;
            we_q      <= fin_w && (op_q == OP_LOAD_DIRECT);
            if (data_rd_q) begin
                wdata_q <= data_rdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign busy_o      = busy_q;
    assign done_o      = done_q;
    assign pc_next_o   = pcn_q;
    assign push_o      = push_q;
    assign ret_addr_o  = ret_q;
    assign io_rd_o     = io_rd_q;
    assign io_addr_o   = io_addr_q;
    assign data_rd_o   = data_rd_q;
    assign data_addr_o = data_addr_q;
    assign reg_we_o    = we_q;
    assign reg_waddr_o = waddr_q;
    assign reg_wdata_o = wdata_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    ext_call_target_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && is_call_w |-> ##1 !done_o [*3] ##1 done_o && push_o &&
        pc_next_o == {$past(ext_high_i, 4), $past(z_ptr_i, 4)})
        else $error("Extended call target or timing wrong.");

    cmp_skip_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_COMPARE_SKIP_EQUAL && rd_val_i == rr_val_i &&
        !two_word_next_i |-> ##1 !done_o [*2] ##1 done_o &&
        pc_next_o == $past(pc_i, 3) + PC_STEP_TWO)
        else $error("Equal compare did not skip one word.");

    regbit_skip_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_SKIP_REG_BIT_SET && rr_val_i[bit_sel_i] &&
        two_word_next_i |-> ##4 done_o &&
        pc_next_o == $past(pc_i, 4) + 22'h3)
        else $error("Set bit did not skip two words.");

    iobit_time_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && is_io_w |-> ##1 io_rd_o && !done_o ##[2:4] done_o)
        else $error("I/O skip timing outside two to four.");

    flag_set_branch_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_BRANCH_STATUS_BIT_SET && flags_i[bit_sel_i]
        |-> ##3 done_o && pc_next_o == $past(pc_i, 3) + PC_STEP +
        bsc_sext_k($past(k_off_i, 3)))
        else $error("Taken status branch wrong.");

    flag_clear_seq_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_BRANCH_STATUS_BIT_CLEAR && flags_i[bit_sel_i]
        |-> ##2 done_o && pc_next_o == $past(pc_i, 2) + PC_STEP)
        else $error("Untaken status branch wrong.");

    signed_ge_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_BRANCH_SIGNED_GE &&
        (flags_i[FLAG_N] ^ flags_i[FLAG_V]) |-> ##2 done_o)
        else $error("Signed branch taken when less.");

    unsigned_alias_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_BRANCH_UNSIGNED_GE && !flags_i[FLAG_C]
        |-> ##1 !done_o [*2] ##1 done_o)
        else $error("Unsigned branch not taken on clear carry.");

    back_branch_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && op_i == OP_BRANCH_CARRY_SET && flags_i[FLAG_C] &&
        k_off_i == 7'h7e |-> ##2 pc_next_o == $past(pc_i, 2) - PC_STEP)
        else $error("Backward branch offset not signed.");

    direct_load_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i || !ce_i)
        go_w && is_load_w |-> ##1 data_rd_o &&
        data_addr_o == $past(load_addr_i) ##2 done_o && reg_we_o &&
        reg_wdata_o == $past(data_rdata_i, 2))
        else $error("Direct load byte or timing wrong.");

endmodule

// ---- testbench/bsc_branch_skip_call_unit_tb_top.sv ----
// Self-checking bench for the branch, skip and call unit.
// Assumes the package and the design files are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module bsc_branch_skip_call_unit_tb_top;
    import bsc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic            clk_sys_i = 0, arst_n_i = 0, ce_i = 1, issue_i = 0;
    logic            two_word_next_i = 0;
    bsc_op_t         op_i = OP_NONE;
    logic [PC_W-1:0] pc_i = 22'h000100, pc_next_o, ret_addr_o;
    logic [7:0]      rd_val_i = 0, rr_val_i = 0, flags_i = 0, io_rdata_i = 0;
    logic [7:0]      data_rdata_i = 0, reg_wdata_o;
    logic [4:0]      dest_i = 0, io_addr_i = 0, io_addr_o, reg_waddr_o;
    logic [2:0]      bit_sel_i = 0;
    logic [6:0]      k_off_i = 0;
    logic [15:0]     z_ptr_i = 0, load_addr_i = 0, data_addr_o;
    logic [5:0]      ext_high_i = 0;
    logic            io_rd_o, data_rd_o, busy_o, done_o, push_o, reg_we_o;
    int              num_errors = 0, total_checks = 0;
    logic [2:0]      strobe_seen; // Busy and read strobes after accept.

    bsc_branch_skip_call_unit u_bsc_branch_skip_call_unit (.clk_sys_i,
        .arst_n_i, .ce_i, .issue_i, .op_i, .pc_i, .rd_val_i, .rr_val_i,
        .dest_i, .bit_sel_i, .k_off_i, .two_word_next_i, .z_ptr_i,
        .ext_high_i, .flags_i, .load_addr_i, .io_addr_i, .io_rd_o, .io_addr_o,
        .io_rdata_i, .data_rd_o, .data_addr_o, .data_rdata_i, .busy_o,
        .done_o, .pc_next_o, .push_o, .ret_addr_o, .reg_we_o,
        .reg_waddr_o, .reg_wdata_o);

    // The clock toggles every 4 ns, half its period of 8 ns.
    initial forever #4 clk_sys_i = ~clk_sys_i;

    // Issues one operation, counts edges to done and checks the target.
    task automatic do_op(input bsc_op_t op, input int n_exp,
                         input logic [PC_W-1:0] pc_exp);
        int n;
        op_i = op;
        issue_i = 1'b1;
        @(posedge clk_sys_i);
        #1 issue_i = 1'b0;
        strobe_seen = {busy_o, io_rd_o, data_rd_o};
        n = 0;
        while (done_o !== 1'b1 && n < 10) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        `CHK("cycles", n_exp, n)
        `CHK("pc_next", pc_exp, pc_next_o)
    endtask

    // Works out from the flags whether a branch should be taken.
    function automatic logic br_take(input bsc_op_t op, input logic [7:0] s);
        case (op)
            OP_BRANCH_STATUS_BIT_SET:      return s[1];
            OP_BRANCH_STATUS_BIT_CLEAR:    return !s[1];
            OP_BRANCH_SIGNED_GE:           return !(s[FLAG_N] ^ s[FLAG_V]);
            OP_BRANCH_SIGNED_LT:           return s[FLAG_N] ^ s[FLAG_V];
            OP_BRANCH_HALF_CARRY_SET:      return s[FLAG_H];
            OP_BRANCH_HALF_CARRY_CLEAR:    return !s[FLAG_H];
            OP_BRANCH_OVERFLOW_SET:        return s[FLAG_V];
            OP_BRANCH_OVERFLOW_CLEAR:      return !s[FLAG_V];
            OP_BRANCH_CARRY_SET,
            OP_BRANCH_UNSIGNED_LT:         return s[FLAG_C];
            OP_BRANCH_CARRY_CLEAR,
            OP_BRANCH_UNSIGNED_GE:         return !s[FLAG_C];
            OP_BRANCH_TRANSFER_FLAG_SET:   return s[FLAG_T];
            default:                       return !s[FLAG_T];
        endcase
    endfunction

    // Every branch under three flag patterns, backward offset of two.
    task automatic t_branch();
        logic [7:0] sv [3] = '{8'h00, 8'hff, 8'h08};
        bsc_op_t op;
        logic t;
        int n;
        logic [PC_W-1:0] pe;
        k_off_i = 7'h7e;
        bit_sel_i = 3'h1;
        foreach (sv[i]) begin
            for (int o = 7; o <= 20; o++) begin
                op = bsc_op_t'(o);
                flags_i = sv[i];
                t = br_take(op, sv[i]);
                n = t ? 2 : 1;
                pe = t ? pc_i - 22'h1 : pc_i + 22'h1;
                case (o)
                    7, 8: do_op(op, n, pe);
                    9, 10: do_op(op, n, pe);
                    11, 12, 13, 14: do_op(op, n, pe);
                    default: do_op(op, n, pe);
                endcase
            end
        end
        $display("test branch done");
    endtask

    // Register compare and register bit skips, one and two words.
    task automatic t_skip();
        rd_val_i = 8'h5a;
        rr_val_i = 8'h5a;
        do_op(OP_COMPARE_SKIP_EQUAL, 2, pc_i + 22'h2);
        two_word_next_i = 1'b1;
        do_op(OP_COMPARE_SKIP_EQUAL, 3, pc_i + 22'h3);
        rr_val_i = 8'h10;
        bit_sel_i = 3'h3;
        do_op(OP_SKIP_REG_BIT_CLEAR, 3, pc_i + 22'h3);
        do_op(OP_SKIP_REG_BIT_SET, 1, pc_i + 22'h1);
        two_word_next_i = 1'b0;
        do_op(OP_COMPARE_SKIP_EQUAL, 1, pc_i + 22'h1);
        bit_sel_i = 3'h4;
        do_op(OP_SKIP_REG_BIT_SET, 2, pc_i + 22'h2);
        two_word_next_i = 1'b1;
        do_op(OP_SKIP_REG_BIT_SET, 3, pc_i + 22'h3);
        two_word_next_i = 1'b0;
        $display("test skip done");
    endtask

    // I/O bit skips with the read strobe address checked.
    task automatic t_io();
        io_rdata_i = 8'h80;
        io_addr_i = 5'h1f;
        bit_sel_i = 3'h7;
        do_op(OP_SKIP_IO_BIT_CLEAR, 2, pc_i + 22'h1);
        `CHK("io_addr", 5'h1f, io_addr_o)
        `CHK("strobes", 3'b110, strobe_seen)
        do_op(OP_SKIP_IO_BIT_SET, 3, pc_i + 22'h2);
        two_word_next_i = 1'b1;
        do_op(OP_SKIP_IO_BIT_SET, 4, pc_i + 22'h3);
        two_word_next_i = 1'b0;
        $display("test io done");
    endtask

    // Extended call, direct load and an ignored empty request.
    task automatic t_call_load();
        z_ptr_i = 16'hbeef;
        ext_high_i = 6'h2a;
        do_op(OP_EXTENDED_INDIRECT_CALL, 3, {6'h2a, 16'hbeef});
        `CHK("push", 1'b1, push_o)
        `CHK("ret_addr", pc_i + 22'h1, ret_addr_o)
        load_addr_i = 16'hc3a5;
        data_rdata_i = 8'h96;
        dest_i = 5'h1b;
        do_op(OP_LOAD_DIRECT, 2, pc_i + 22'h2);
        `CHK("strobes", 3'b101, strobe_seen)
        `CHK("reg_we", 1'b1, reg_we_o)
        `CHK("reg_waddr", 5'h1b, reg_waddr_o)
        `CHK("reg_wdata", 8'h96, reg_wdata_o)
        `CHK("data_addr", 16'hc3a5, data_addr_o)
        op_i = OP_NONE;
        issue_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 issue_i = 1'b0;
        `CHK("busy", 1'b0, busy_o)
        $display("test call_load done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence after two cycles of reset.
    initial begin
        repeat (2) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        t_skip();
        t_io();
        t_call_load();
        t_branch();
        final_report();
    end

    // Watchdog, far beyond the roughly 150 cycles the tests need.
    initial begin
        #40000;
        num_errors++;
        final_report();
    end
endmodule
